// ==== hw/fpp_pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module fpp_pin_sync
#(
  parameter logic INIT = 1'b0
)
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic PIN,
  output logic LEVEL
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  // Shift chain; first stage feeds only the second
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      lvl_q <= INIT;
    end
    else
    begin
      s1_q <= PIN;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        lvl_q <= s3_q;
    end
  end
  assign LEVEL = lvl_q;
endmodule // fpp_pin_sync

// ==== hw/fpp_pkg.sv ====
// Package: register map, field layout and constants for flash protection
// Operation
// - Write-enable pin low clears control one and erase select, blocks all.
// - Any reset or standby initialises all flash registers, protected state.
// - Error flag set aborts program or erase, registers kept.
// - Under error protection program/erase bits store but no mode entry.
// - Under error protection verify bits still enter verify mode.
// - Error state cleared only by reset pin, watchdog or hardware standby.
// - Flash read during program/erase sets error flag.
// - Exception during program/erase sets error flag, except listed ones.
// - Sleep or software standby during program/erase sets error flag.
// - Bus grant to other master during program/erase sets error flag.
// - Program/erase condition is program or erase bit of control one set.
// - Registers writable under error, but cleared on software standby.
// - Erase select gates erase per block; zero protects all blocks.
// - Emulation select protects all blocks; verify allowed.
// - Hardware, emulation or error protection refuses erase for all blocks.
// - Non-maskable interrupt blocked while program or erase bit set.
// - Non-maskable interrupt blocked in error state and during emulation; NMI_OUT is not gated by emulation select.
// - Boot mode blocks non-maskable interrupt until branch to boot area.
// - Flash reads during program/erase may return undefined value.
// - Program and erase bits clear when write-enable bit is zero.
package fpp_pkg;
  localparam logic [11:0] OFF_CTRL_ONE = 12'h000;
  localparam logic [11:0] OFF_CTRL_TWO = 12'h004;
  localparam logic [11:0] OFF_ERASE_SEL = 12'h008;
  localparam logic [11:0] OFF_RAM_OVL = 12'h00C;
  localparam logic [11:0] OFF_STATUS = 12'h010;
  // Control one field positions
  localparam int B_PROG = 0;
  localparam int B_ERASE = 1;
  localparam int B_PV = 2;
  localparam int B_EV = 3;
  localparam int B_PSU = 4;
  localparam int B_ESU = 5;
  localparam int B_SWE = 6;
  localparam int CTRL_ONE_W = 7;
  // Control two field position (error flag, read only)
  localparam int B_ERR = 7;
  // Ram overlay control field position
  localparam int B_RAM_EMULATION_SELECT = 3;
  localparam int RAM_OVL_W = 4;
  localparam logic [6:0] CTRL_ONE_RST = 7'h00;
  localparam logic [3:0] RAM_OVL_RST = 4'h0;
  localparam logic [23:0] BOOT_RAM_ADDR = 24'hFFEF10;
  localparam int RESET_MIN_CYC = 20;
  localparam int SYNC_W = 3;
  typedef enum logic [1:0] {
    FPP_IDLE = 2'b00,
    FPP_PROG = 2'b01,
    FPP_ERASE = 2'b11,
    FPP_VERIFY = 2'b10
  } fpp_mode_e;
endpackage

// ==== hw/fpp_top.sv ====
// Flash program/erase protection with APB register slave
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module fpp_top
#(
  parameter int NUM_BLOCKS = 16
)
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [11:0] PADDR,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic FLASH_WRITE_ENABLE_PIN,
  input wire logic WDT_RESET,
  input wire logic HW_STANDBY,
  input wire logic SW_STANDBY,
  input wire logic SLEEP_EXEC,
  input wire logic FLASH_READ,
  input wire logic EXCEPTION_TAKEN,
  input wire logic EXCEPTION_EXEMPT,
  input wire logic BUS_GRANT_OTHER,
  input wire logic BOOT_MODE,
  input wire logic [23:0] FETCH_ADDR,
  input wire logic FETCH_VALID,
  input wire logic NMI_REQ,
  output logic NMI_OUT,
  output logic PROGRAM_MODE,
  output logic ERASE_MODE,
  output logic VERIFY_MODE,
  output logic [NUM_BLOCKS-1:0] ERASE_BLOCKS,
  output logic RAM_OVERLAY_WRITABLE,
  output logic FLASH_DATA_UNDEFINED,
  output logic FLASH_ERROR_FLAG
);
  logic [6:0] ctrl_one_q;
  logic [6:0] ctrl_one_d;
  logic [NUM_BLOCKS-1:0] erase_sel_q;
  logic [NUM_BLOCKS-1:0] erase_sel_d;
  logic [3:0] ram_ovl_q;
  logic err_q;
  logic boot_lock_q;
  fpp_pkg::fpp_mode_e mode_q;
  fpp_pkg::fpp_mode_e mode_d;
  logic [31:0] prdata_q;
  logic fwe_lvl;
  logic [31:0] rd_mux;

  // Write-enable pin comes from outside: filtered synchroniser
  fpp_pin_sync #(.INIT(1'b0)) u_fwe_sync
  (
    .CLK(CLK),
    .RESET(RESET),
    .PIN(FLASH_WRITE_ENABLE_PIN),
    .LEVEL(fwe_lvl)
  );

  // Bus decode
  wire wr_cyc = PSEL && PENABLE && PWRITE;
  wire rd_cyc = PSEL && PENABLE && !PWRITE;
  wire hit_c1 = PADDR == fpp_pkg::OFF_CTRL_ONE;
  wire hit_c2 = PADDR == fpp_pkg::OFF_CTRL_TWO;
  wire hit_es = PADDR == fpp_pkg::OFF_ERASE_SEL;
  wire hit_ro = PADDR == fpp_pkg::OFF_RAM_OVL;
  wire hit_st = PADDR == fpp_pkg::OFF_STATUS;
  wire mapped = hit_c1 || hit_c2 || hit_es || hit_ro || hit_st;

  // Protection conditions
  wire full_reset = WDT_RESET || HW_STANDBY;
  wire reg_init = full_reset || SW_STANDBY;
  wire pin_low = !fwe_lvl;
  wire swe_off = !ctrl_one_q[fpp_pkg::B_SWE];
  wire emul_on = ram_ovl_q[fpp_pkg::B_RAM_EMULATION_SELECT];
  wire prog_bit = ctrl_one_q[fpp_pkg::B_PROG];
  wire erase_bit = ctrl_one_q[fpp_pkg::B_ERASE];
  wire pe_active = prog_bit || erase_bit;
  wire no_pe = pin_low || emul_on || err_q;
  wire erase_ok = !no_pe && (|erase_sel_q);
  wire err_event = pe_active && !pin_low && (FLASH_READ
    || (EXCEPTION_TAKEN && !EXCEPTION_EXEMPT)
    || SLEEP_EXEC || SW_STANDBY
    || BUS_GRANT_OTHER);

  // Control one next value: pin low or write-enable off clears bits
  always_comb
  begin
    ctrl_one_d = ctrl_one_q;
    if (wr_cyc && hit_c1)
      ctrl_one_d = PWDATA[fpp_pkg::CTRL_ONE_W-1:0];
    if (!ctrl_one_d[fpp_pkg::B_SWE])
    begin
      ctrl_one_d[fpp_pkg::B_PROG] = 1'b0;
      ctrl_one_d[fpp_pkg::B_ERASE] = 1'b0;
    end
    if (pin_low || reg_init)
      ctrl_one_d = fpp_pkg::CTRL_ONE_RST;
  end

  // Erase select next value
  always_comb
  begin
    erase_sel_d = erase_sel_q;
    if (wr_cyc && hit_es)
      erase_sel_d = PWDATA[NUM_BLOCKS-1:0];
    if (pin_low || reg_init)
      erase_sel_d = '0;
  end

  // Operating mode: error aborts at once, verify still allowed
  always_comb
  begin
    mode_d = fpp_pkg::FPP_IDLE;
    if (pin_low)
      mode_d = fpp_pkg::FPP_IDLE;
    else if (prog_bit && !no_pe && !err_event)
      mode_d = fpp_pkg::FPP_PROG;
    else if (erase_bit && erase_ok && !err_event)
      mode_d = fpp_pkg::FPP_ERASE;
    else if (ctrl_one_q[fpp_pkg::B_PV] || ctrl_one_q[fpp_pkg::B_EV])
      mode_d = fpp_pkg::FPP_VERIFY;
  end

  // Register updates
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      ctrl_one_q <= fpp_pkg::CTRL_ONE_RST;
      erase_sel_q <= '0;
      ram_ovl_q <= fpp_pkg::RAM_OVL_RST;
      mode_q <= fpp_pkg::FPP_IDLE;
    end
    else
    begin
      ctrl_one_q <= ctrl_one_d;
      erase_sel_q <= erase_sel_d;
      mode_q <= mode_d;
      if (wr_cyc && hit_ro)
        ram_ovl_q <= PWDATA[fpp_pkg::RAM_OVL_W-1:0];
    end
  end

  // Error flag: set by events, cleared only by full resets
  always_ff @(posedge CLK)
  begin
    if (RESET)
      err_q <= 1'b0;
    else if (err_event)
      err_q <= 1'b1;
    else if (full_reset)
      err_q <= 1'b0;
  end

  // Boot lock: armed at reset in boot mode, released at boot area branch
  always_ff @(posedge CLK)
  begin
    if (RESET)
      boot_lock_q <= 1'b1;
    else if (!BOOT_MODE)
      boot_lock_q <= 1'b0;
    else if (FETCH_VALID && FETCH_ADDR == fpp_pkg::BOOT_RAM_ADDR)
      boot_lock_q <= 1'b0;
  end

  // Read mux
  assign rd_mux = hit_c1 ? {25'h0, ctrl_one_q}
    : hit_c2 ? {24'h000000, err_q, 7'h00}
    : hit_es ? 32'(erase_sel_q)
    : hit_ro ? {28'h0000000, ram_ovl_q}
    : hit_st ? {30'h0, mode_q}
    : 32'h00000000;

  // Read data register
  always_ff @(posedge CLK)
  begin
    if (RESET)
      prdata_q <= 32'h00000000;
    else if (PSEL && !PENABLE && !PWRITE)
      prdata_q <= rd_mux;
  end

  // Bus answers: zero wait states, error on unmapped address
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;
  assign PRDATA = prdata_q;

  // Outputs
  assign NMI_OUT = NMI_REQ && !pe_active && !err_q
    && !(BOOT_MODE && boot_lock_q);
  assign PROGRAM_MODE = mode_q == fpp_pkg::FPP_PROG;
  assign ERASE_MODE = mode_q == fpp_pkg::FPP_ERASE;
  assign VERIFY_MODE = mode_q == fpp_pkg::FPP_VERIFY;
  assign ERASE_BLOCKS = ERASE_MODE ? erase_sel_q : '0;
  assign RAM_OVERLAY_WRITABLE = emul_on;
  assign FLASH_DATA_UNDEFINED = pe_active;
  assign FLASH_ERROR_FLAG = err_q;

  // Checks: interrupt gating while programming or erasing
  nmi_block_a: assert property (@(posedge CLK) disable iff (RESET)
    (pe_active || err_q)
    |-> !NMI_OUT)
    else $error("nmi passed while protected");

  // Checks: error flag only released by a full reset
  err_sticky_a: assert property (@(posedge CLK) disable iff (RESET)
    err_q && !full_reset
    |=> err_q)
    else $error("error flag cleared without reset");

  // Checks: an error event ends program and erase modes
  err_set_a: assert property (@(posedge CLK) disable iff (RESET)
    err_event
    |=> err_q ##1 !PROGRAM_MODE && !ERASE_MODE)
    else $error("error did not abort");

  // Checks: no program or erase mode under error protection
  err_noprog_a: assert property (@(posedge CLK) disable iff (RESET)
    $past(err_q)
    |-> !PROGRAM_MODE && !ERASE_MODE)
    else $error("mode entered under error");

  // Checks: pin low wipes control one and erase select
  pin_clear_a: assert property (@(posedge CLK) disable iff (RESET)
    pin_low
    |=> ctrl_one_q == fpp_pkg::CTRL_ONE_RST && erase_sel_q == '0)
    else $error("pin low did not clear");

  // Checks: emulation select keeps every block protected
  emul_prot_a: assert property (@(posedge CLK) disable iff (RESET)
    $past(emul_on)
    |-> !PROGRAM_MODE && !ERASE_MODE)
    else $error("mode entered under emulation");

  // Checks: an empty erase select protects all blocks
  erase_zero_a: assert property (@(posedge CLK) disable iff (RESET)
    $past(erase_sel_q) == '0
    |-> !ERASE_MODE)
    else $error("erase with no block");

  // Checks: write enable bit off forces program and erase bits low
  swe_clear_a: assert property (@(posedge CLK) disable iff (RESET)
    swe_off
    |-> !prog_bit && !erase_bit)
    else $error("program bit with write enable off");

  // Checks: software standby initialises control one
  sstby_init_a: assert property (@(posedge CLK) disable iff (RESET)
    SW_STANDBY
    |=> ctrl_one_q == fpp_pkg::CTRL_ONE_RST)
    else $error("standby did not init");

  // Checks: software standby initialises erase select too
  sstby_ebr_a: assert property (@(posedge CLK) disable iff (RESET)
    SW_STANDBY
    |=> erase_sel_q == '0)
    else $error("standby did not clear erase select");

  // Checks: pin low leaves no mode at all, verify included
  pin_mode_a: assert property (@(posedge CLK) disable iff (RESET)
    $past(pin_low)
    |-> !PROGRAM_MODE && !ERASE_MODE && !VERIFY_MODE)
    else $error("mode active with pin low");

  // Checks: program mode only from a set program bit
  prog_bit_a: assert property (@(posedge CLK) disable iff (RESET)
    PROGRAM_MODE
    |-> $past(prog_bit))
    else $error("program mode without program bit");

  // Checks: erase mode only from a set erase bit
  erase_bit_a: assert property (@(posedge CLK) disable iff (RESET)
    ERASE_MODE
    |-> $past(erase_bit))
    else $error("erase mode without erase bit");

  // Checks: program-verify still reachable, error or not
  pv_verify_a: assert property (@(posedge CLK) disable iff (RESET)
    $past(!pin_low && ctrl_one_q[fpp_pkg::B_PV] && !pe_active)
    |-> VERIFY_MODE)
    else $error("program verify refused");

  // Checks: erase-verify still reachable, error or not
  ev_verify_a: assert property (@(posedge CLK) disable iff (RESET)
    $past(!pin_low && ctrl_one_q[fpp_pkg::B_EV] && !pe_active)
    |-> VERIFY_MODE)
    else $error("erase verify refused");

  // Checks: an error keeps control one as it was
  err_keep_a: assert property (@(posedge CLK) disable iff (RESET)
    err_event && !reg_init && !(wr_cyc && hit_c1)
    |=> ctrl_one_q == $past(ctrl_one_q))
    else $error("error changed control one");

  // Checks: an error keeps the erase select as it was
  ebr_keep_a: assert property (@(posedge CLK) disable iff (RESET)
    err_event && !reg_init && !(wr_cyc && hit_es)
    |=> erase_sel_q == $past(erase_sel_q))
    else $error("error changed erase select");

  // Checks: a write to control two cannot clear the flag
  err_write_a: assert property (@(posedge CLK) disable iff (RESET)
    wr_cyc && hit_c2 && err_q && !full_reset
    |=> err_q)
    else $error("write cleared error flag");

  // Checks: watchdog or hardware standby releases the flag
  full_clear_a: assert property (@(posedge CLK) disable iff (RESET)
    full_reset && !err_event
    |=> !err_q)
    else $error("full reset kept error flag");

  // Checks: a full reset initialises both flash registers
  reset_init_a: assert property (@(posedge CLK) disable iff (RESET)
    full_reset
    |=> ctrl_one_q == fpp_pkg::CTRL_ONE_RST && erase_sel_q == '0)
    else $error("full reset did not init");

  // Checks: flash reads flagged undefined while bits are set
  undef_rd_a: assert property (@(posedge CLK) disable iff (RESET)
    pe_active
    |-> FLASH_DATA_UNDEFINED)
    else $error("reads not flagged undefined");

  // Checks: no interrupt before the boot area branch
  boot_nmi_a: assert property (@(posedge CLK) disable iff (RESET)
    BOOT_MODE && boot_lock_q
    |-> !NMI_OUT)
    else $error("nmi passed in boot lock");

  // Checks: error protection also masks the interrupt
  err_nmi_a: assert property (@(posedge CLK) disable iff (RESET)
    err_q
    |-> !NMI_OUT)
    else $error("nmi passed under error");

  // Checks: overlapping ram stays writable under emulation
  ram_emul_a: assert property (@(posedge CLK) disable iff (RESET)
    emul_on
    |-> RAM_OVERLAY_WRITABLE)
    else $error("overlay ram not writable");

  // Checks: hardware or error protection refuses erase of all blocks
  erase_all_a: assert property (@(posedge CLK) disable iff (RESET)
    pin_low || err_q
    |=> ERASE_BLOCKS == '0)
    else $error("block erase under protection");

  // Checks: pin low never raises the error flag
  pin_err_a: assert property (@(posedge CLK) disable iff (RESET)
    pin_low && !err_q
    |=> !err_q)
    else $error("error raised with pin low");
endmodule // fpp_top

// ==== sim/fpp_core_model.sv ====
// Core-side model: APB master that runs the flash register accesses
`timescale 1ns/1ps
module fpp_core_model
(
  input wire logic CLK,
  output logic [11:0] PADDR,
  output logic PSEL,
  output logic PENABLE,
  output logic PWRITE,
  output logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR
);
  // Bus idle at time zero
  initial
  begin
    PADDR = 12'h000;
    PSEL = 1'h0;
    PENABLE = 1'h0;
    PWRITE = 1'h0;
    PWDATA = 32'h0;
  end
  // One transfer, entered just after a rising edge; waits for ready
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic err);
    PADDR <= a;
    PWRITE <= w;
    PWDATA <= d;
    PSEL <= 1'h1;
    @(posedge CLK);
    PENABLE <= 1'h1;
    @(posedge CLK);
    while (PREADY !== 1'h1)
      @(posedge CLK);
    r = PRDATA;
    err = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
    PWDATA <= ~d; // Released data no longer shows the last value
  endtask
endmodule // fpp_core_model

// ==== sim/test_flash_program_erase_protection.sv ====
// Testbench: flash program/erase protection scenarios
`timescale 1ns/1ps
module test_flash_program_erase_protection;
  logic clk, reset, flash_write_enable_pin, wdt, hws, sws, exx, boot, fval, nmi_req, e;
  logic psel, penable, pwrite, pready, pslverr, nmi_out, pm, em, vm;
  logic ramw, fund, ferr;
  logic [3:0] ev;
  logic [23:0] faddr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] eblk;
  int failures, checked;
  // Device under test and the core-side model
  fpp_top u_fpp_top (.CLK(clk), .RESET(reset), .PADDR(paddr), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .FLASH_WRITE_ENABLE_PIN(flash_write_enable_pin),
    .WDT_RESET(wdt), .HW_STANDBY(hws), .SW_STANDBY(sws),
    .SLEEP_EXEC(ev[1]), .FLASH_READ(ev[0]), .EXCEPTION_TAKEN(ev[2]),
    .EXCEPTION_EXEMPT(exx), .BUS_GRANT_OTHER(ev[3]), .BOOT_MODE(boot),
    .FETCH_ADDR(faddr), .FETCH_VALID(fval), .NMI_REQ(nmi_req),
    .NMI_OUT(nmi_out), .PROGRAM_MODE(pm), .ERASE_MODE(em),
    .VERIFY_MODE(vm), .ERASE_BLOCKS(eblk), .RAM_OVERLAY_WRITABLE(ramw),
    .FLASH_DATA_UNDEFINED(fund), .FLASH_ERROR_FLAG(ferr));
  fpp_core_model u_fpp_core_model (.CLK(clk), .PADDR(paddr), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr));
  // 50 MHz clock
  initial
  begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  // Value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Wait past the next edge, look at the falling edge
  task automatic gap;
    @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    u_fpp_core_model.xfer(1'h1, a, d, rd, e);
    gap;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    u_fpp_core_model.xfer(1'h0, a, 32'h0, rd, e);
    chk(rd, exp);
    gap;
  endtask
  // One-cycle event pulse on the chosen line
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'h1;
    @(posedge clk);
    ev[i] <= 1'h0;
    gap;
  endtask
  task automatic wdt_clear;
    @(posedge clk);
    wdt <= 1'h1;
    @(posedge clk);
    wdt <= 1'h0;
    gap;
  endtask
  task automatic t_reset;
    rdc(12'h000, 32'h0);
    rdc(12'h004, 32'h0);
    rdc(12'h008, 32'h0);
    rdc(12'h020, 32'h0);
    chk(e, 1'h1);
    $display("test reset done");
  endtask
  task automatic t_error;
    @(posedge clk);
    flash_write_enable_pin <= 1'h1;
    nmi_req <= 1'h1;
    repeat (8) gap;
    chk(nmi_out, 1'h1);
    wr(12'h000, 32'h41);
    chk({pm, fund, nmi_out}, 3'h6);
    pulse(0);
    chk({pm, ferr}, 2'h1);
    rdc(12'h000, 32'h41);
    wr(12'h004, 32'h0);
    rdc(12'h004, 32'h80);
    wr(12'h000, 32'h41);
    chk({pm, nmi_out}, 2'h0);
    wr(12'h000, 32'h44);
    chk(vm, 1'h1);
    rdc(12'h010, 32'h2);
    @(posedge clk);
    sws <= 1'h1;
    @(posedge clk);
    sws <= 1'h0;
    rdc(12'h000, 32'h0);
    chk(ferr, 1'h1);
    wdt_clear;
    chk(ferr, 1'h0);
    $display("test error protection done");
  endtask
  task automatic t_events;
    for (int i = 1; i < 4; i++)
    begin
      wr(12'h000, 32'h41);
      pulse(i);
      chk({pm, ferr}, 2'h1);
      wdt_clear;
    end
    wr(12'h000, 32'h41);
    @(posedge clk);
    exx <= 1'h1;
    pulse(2);
    @(posedge clk);
    exx <= 1'h0;
    chk({pm, ferr}, 2'h2);
    wr(12'h000, 32'h40);
    pulse(0);
    chk(ferr, 1'h0);
    $display("test error events done");
  endtask
  task automatic t_erase;
    wr(12'h000, 32'h42);
    chk(eblk, 16'h0);
    wr(12'h000, 32'h40);
    wr(12'h008, 32'h5);
    wr(12'h000, 32'h42);
    chk({em, eblk}, 17'h10005);
    wr(12'h000, 32'h40);
    wr(12'h00C, 32'h8);
    wr(12'h000, 32'h42);
    chk({em, eblk, ramw, nmi_out}, 19'h2);
    wr(12'h000, 32'h41);
    chk(pm, 1'h0);
    wr(12'h000, 32'h44);
    chk(vm, 1'h1);
    wr(12'h00C, 32'h0);
    wr(12'h008, 32'h0);
    $display("test erase gating done");
  endtask
  task automatic t_fwe;
    @(posedge clk);
    nmi_req <= 1'h0;
    wr(12'h008, 32'h5);
    wr(12'h000, 32'h41);
    @(posedge clk);
    flash_write_enable_pin <= 1'h0;
    repeat (8) gap;
    chk(pm, 1'h0);
    rdc(12'h000, 32'h0);
    rdc(12'h008, 32'h0);
    @(posedge clk);
    flash_write_enable_pin <= 1'h1;
    repeat (8) gap;
    wr(12'h000, 32'h01);
    rdc(12'h000, 32'h0);
    $display("test write enable pin done");
  endtask
  task automatic t_boot;
    @(posedge clk);
    boot <= 1'h1;
    nmi_req <= 1'h1;
    reset <= 1'h1;
    repeat (20) @(posedge clk);
    reset <= 1'h0;
    repeat (8) gap;
    chk(nmi_out, 1'h0);
    @(posedge clk);
    faddr <= 24'hFFEF10;
    fval <= 1'h1;
    @(posedge clk);
    fval <= 1'h0;
    gap;
    chk(nmi_out, 1'h1);
    wr(12'h000, 32'h41);
    pulse(0);
    @(posedge clk);
    hws <= 1'h1;
    @(posedge clk);
    hws <= 1'h0;
    gap;
    chk(ferr, 1'h0);
    rdc(12'h000, 32'h0);
    $display("test boot and standby done");
  endtask
  task automatic give_verdict;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Watchdog against a hang
  initial
  begin
    repeat (5000) @(posedge clk);
    failures++;
    give_verdict;
  end
  // Main sequence
  initial
  begin
    {reset, flash_write_enable_pin, wdt, hws, sws, exx, boot, fval, nmi_req} = 9'h100;
    ev = 4'h0;
    faddr = 24'h0;
    failures = 0;
    checked = 0;
    repeat (10) @(posedge clk);
    reset <= 1'h0;
    t_reset;
    t_error;
    t_events;
    t_erase;
    t_fwe;
    t_boot;
    give_verdict;
  end
endmodule // test_flash_program_erase_protection
